// File: nand_host_pkg.sv
// Package for the flash card host controller: command codes, address layout,
// limits and pin timing counts at a 50 MHz mclk.
package nand_host_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // Pin timing figures in ns, least times round up
  localparam int unsigned T_WP_NS   = 25;
  localparam int unsigned T_WH_NS   = 15;
  localparam int unsigned T_RP_NS   = 30;
  localparam int unsigned T_REH_NS  = 15;
  localparam int unsigned T_REA_NS  = 35;
  localparam int unsigned T_WHR_NS  = 60;
  localparam int unsigned T_WB_NS   = 100;
  localparam int unsigned T_CEH_NS  = 100;

  localparam int unsigned WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WH_CYC  = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC0 = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC1 = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC  = (RP_CYC0 > RP_CYC1) ? RP_CYC0 : RP_CYC1;
  localparam int unsigned REH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WB_CYC  = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CEH_CYC = (T_CEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned TMR_W = 4;

  // Command codes
  localparam logic [7:0] CMD_DATA_IN   = 8'h80;
  localparam logic [7:0] CMD_READ_LO   = 8'h00;
  localparam logic [7:0] CMD_READ_HI   = 8'h01;
  localparam logic [7:0] CMD_READ_SPR  = 8'h50;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_PROGRAM   = 8'h10;
  localparam logic [7:0] CMD_ERASE_SET = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;

  // Row address: 14 bits, blocks of 16 pages
  localparam int unsigned ROW_W      = 14;
  localparam int unsigned BLOCK_W    = 10;
  localparam int unsigned PAGE_LSB_W = 4;
  localparam int unsigned ROW_HI_W   = 6;
  localparam int unsigned PP_W       = 4;
  localparam logic [PP_W-1:0] PARTIAL_PROG_MAX = 4'hA;
  localparam int unsigned BLOCKS     = 1024;
  localparam int unsigned LEN_W      = 10;

  // Host request kinds
  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_ERASE   = 3'b010,
    OP_STATUS  = 3'b011,
    OP_ID      = 3'b100,
    OP_RESET   = 3'b101
  } op_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD   = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_WAITB = 4'b0011,
    ST_RDWT  = 4'b0100,
    ST_RDAT  = 4'b0101,
    ST_WDAT  = 4'b0110,
    ST_CMD2  = 4'b0111,
    ST_CEH   = 4'b1000,
    ST_DONE  = 4'b1001
  } state_type;

endpackage

// File: nand_card_host.sv
// Host controller for a small-page NAND flash card: runs read, program,
// erase, status, identification and reset sequences on the card pins.
// Assumes ready_busy_in already sees the external pull-up level.
`timescale 1ns/1ps

module nand_card_host
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // Request port
  input  wire logic             req_valid,
  input  wire op_type           req_op,
  input  wire logic             req_half,
  input  wire logic [7:0]       req_col,
  input  wire logic [ROW_W-1:0] req_row,
  input  wire logic [LEN_W-1:0] req_len,
  input  wire logic             req_bad_block,
  output logic                  req_ready,
  // Data streams
  input  wire logic [7:0]       wr_data,
  output logic                  wr_take,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  output logic                  done,
  output logic                  refused,
  // Card pins
  output logic                  cmd_latch,
  output logic                  addr_latch,
  output logic                  chip_sel_n,
  output logic                  write_strobe_n,
  output logic                  output_strobe_n,
  output logic                  write_guard_n,
  output logic [7:0]            io_out,
  output logic                  io_oe,
  input  wire logic [7:0]       io_in,
  input  wire logic             ready_busy_in
);

  state_type             state_q, state_d;
  op_type                op_q, op_d;
  logic [TMR_W-1:0]      tmr_q, tmr_d;
  logic                  ph_q, ph_d;
  logic [1:0]            idx_q, idx_d;
  logic [LEN_W-1:0]      cnt_q, cnt_d;
  logic [7:0]            col_q, col_d;
  logic [ROW_W-1:0]      row_q, row_d;
  logic [PP_W-1:0]       pp_cnt_q [BLOCKS];
  logic [PP_W-1:0]       pp_cnt_d;
  logic [BLOCK_W-1:0]    pp_idx;
  logic                  pp_we;
  logic                  cle_q, cle_d, ale_q, ale_d, ce_n_q, ce_n_d, we_n_q, we_n_d, re_n_q, re_n_d;
  logic                  wg_n_q, wg_n_d, oe_q, oe_d;
  // Latches and port lag the strobe by one cycle so they hold across its rise
  logic                  cle_pin_q, ale_pin_q, oe_pin_q, oe_pin_d;
  logic [7:0]            io_pin_q;
  logic [7:0]            io_q, io_d, rd_q, rd_d;
  logic                  rdv_q, rdv_d, take_q, take_d, done_q, done_d, ref_q, ref_d, rdy_q, rdy_d;

  function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
    return TMR_W'(n - 1);
  endfunction

  function automatic logic [1:0] addr_count(input op_type op);
    return (op == OP_ERASE) ? 2'h2 : ((op == OP_ID) ? 2'h1 : 2'h3);
  endfunction

  function automatic logic [7:0] first_cmd(input op_type op, input logic half);
    unique case (op)
      OP_READ:    first_cmd = half ? CMD_READ_HI : CMD_READ_LO;
      OP_PROGRAM: first_cmd = CMD_DATA_IN;
      OP_ERASE:   first_cmd = CMD_ERASE_SET;
      OP_STATUS:  first_cmd = CMD_STATUS;
      OP_ID:      first_cmd = CMD_READ_ID;
      OP_RESET:   first_cmd = CMD_RESET;
      default:    first_cmd = CMD_RESET;
    endcase
  endfunction

  assign pp_idx = row_q[ROW_W-1 -: BLOCK_W];

  always_comb begin
    state_d = state_q; op_d = op_q; tmr_d = tmr_q; ph_d = ph_q; idx_d = idx_q;
    cnt_d = cnt_q; col_d = col_q; row_d = row_q;
    cle_d = cle_q; ale_d = ale_q; ce_n_d = ce_n_q; we_n_d = we_n_q; re_n_d = re_n_q;
    wg_n_d = wg_n_q; oe_d = oe_q; io_d = io_q; rd_d = rd_q;
    rdv_d = 1'b0; take_d = 1'b0; done_d = 1'b0; ref_d = 1'b0; rdy_d = 1'b0;
    pp_we = 1'b0; pp_cnt_d = pp_cnt_q[pp_idx];
    if (tmr_q != '0) begin
      tmr_d = tmr_q - TMR_W'(1);
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          rdy_d = 1'b1;
          if (req_valid && rdy_q) begin
            rdy_d = 1'b0;
            if ((req_op == OP_PROGRAM || req_op == OP_ERASE) && req_bad_block) begin
              ref_d = 1'b1;
            end else if (req_op == OP_PROGRAM && pp_cnt_q[req_row[ROW_W-1 -: BLOCK_W]] >= PARTIAL_PROG_MAX) begin
              ref_d = 1'b1;
            end else begin
              op_d = req_op; col_d = req_col; row_d = req_row; cnt_d = req_len;
              wg_n_d = (req_op == OP_PROGRAM || req_op == OP_ERASE);
              io_d = first_cmd(req_op, req_half); ce_n_d = 1'b0;
              ph_d = 1'b0; idx_d = 2'h0; state_d = ST_CMD;
            end
          end
        end
        ST_CMD, ST_CMD2: begin
          if (!ph_q) begin
            cle_d = 1'b1; we_n_d = 1'b0; oe_d = 1'b1; ph_d = 1'b1; tmr_d = cyc(WP_CYC);
          end else begin
            we_n_d = 1'b1; ph_d = 1'b0; tmr_d = cyc(WH_CYC);
            cle_d = 1'b0; oe_d = 1'b0;
            if (state_q == ST_CMD2 || op_q == OP_RESET) begin
              state_d = ST_WAITB; tmr_d = cyc(WB_CYC);
            end else if (op_q == OP_STATUS) begin
              state_d = ST_RDWT; tmr_d = cyc(WHR_CYC);
            end else begin
              state_d = ST_ADDR;
              io_d = (op_q == OP_ERASE) ? row_q[7:0] : ((op_q == OP_ID) ? 8'h00 : col_q);
            end
          end
        end
        ST_ADDR: begin
          if (!ph_q) begin
            ale_d = 1'b1; we_n_d = 1'b0; oe_d = 1'b1; ph_d = 1'b1; tmr_d = cyc(WP_CYC);
          end else begin
            we_n_d = 1'b1; ph_d = 1'b0; tmr_d = cyc(WH_CYC); idx_d = idx_q + 2'h1;
            oe_d = 1'b0;
            io_d = (op_q == OP_ERASE || idx_q != 2'h0) ? 8'(row_q[ROW_W-1:8]) : row_q[7:0];
            if (idx_q + 2'h1 == addr_count(op_q)) begin
              ale_d = 1'b0;
              unique case (op_q)
                OP_ERASE: begin
                  io_d = CMD_ERASE_GO; state_d = ST_CMD2;
                end
                OP_PROGRAM: begin
                  state_d = ST_WDAT; io_d = wr_data; take_d = 1'b1;
                end
                OP_ID: begin
                  state_d = ST_RDWT; tmr_d = cyc(CEH_CYC);
                end
                default: begin
                  state_d = ST_WAITB; tmr_d = cyc(WB_CYC);
                end
              endcase
            end
          end
        end
        ST_WAITB: begin
          if (ready_busy_in) begin
            if (op_q == OP_PROGRAM || op_q == OP_ERASE || op_q == OP_RESET) begin
              wg_n_d = 1'b0; state_d = ST_CEH;
            end else begin
              state_d = ST_RDAT;
            end
          end
        end
        ST_RDWT: begin
          state_d = ST_RDAT;
        end
        ST_RDAT: begin
          if (cnt_q == '0) begin
            state_d = ST_CEH;
          end else if (!ph_q) begin
            re_n_d = 1'b0; ph_d = 1'b1; tmr_d = cyc(RP_CYC);
          end else begin
            rd_d = io_in; rdv_d = 1'b1; re_n_d = 1'b1; ph_d = 1'b0;
            tmr_d = cyc(REH_CYC); cnt_d = cnt_q - LEN_W'(1);
          end
        end
        ST_WDAT: begin
          if (cnt_q == '0) begin
            io_d = CMD_PROGRAM; state_d = ST_CMD2;
            pp_we = 1'b1; pp_cnt_d = pp_cnt_q[pp_idx] + PP_W'(1);
          end else if (!ph_q) begin
            we_n_d = 1'b0; oe_d = 1'b1; ph_d = 1'b1; tmr_d = cyc(WP_CYC);
          end else begin
            we_n_d = 1'b1; oe_d = 1'b0; ph_d = 1'b0; tmr_d = cyc(WH_CYC);
            cnt_d = cnt_q - LEN_W'(1); io_d = wr_data; take_d = (cnt_q != LEN_W'(1));
          end
        end
        ST_CEH: begin
          ce_n_d = 1'b1; tmr_d = cyc(CEH_CYC); state_d = ST_DONE;
        end
        ST_DONE: begin
          ce_n_d = 1'b1; wg_n_d = 1'b0; done_d = 1'b1; state_d = ST_IDLE;
        end
        default: state_d = ST_IDLE;
      endcase
    end
    if (op_q == OP_ERASE && state_q == ST_CMD2 && ph_q && tmr_q == '0) begin
      pp_we = 1'b1; pp_cnt_d = '0;
    end
    oe_pin_d = oe_d | oe_q;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE; op_q <= OP_READ; tmr_q <= '0; ph_q <= 1'b0; idx_q <= 2'h0;
      cnt_q <= '0; col_q <= 8'h00; row_q <= '0;
      cle_pin_q <= 1'b0; ale_pin_q <= 1'b0; oe_pin_q <= 1'b0; io_pin_q <= 8'h00;
      cle_q <= 1'b0; ale_q <= 1'b0; ce_n_q <= 1'b1; we_n_q <= 1'b1; re_n_q <= 1'b1;
      wg_n_q <= 1'b0; oe_q <= 1'b0; io_q <= 8'h00; rd_q <= 8'h00;
      rdv_q <= 1'b0; take_q <= 1'b0; done_q <= 1'b0; ref_q <= 1'b0; rdy_q <= 1'b0;
      for (int i = 0; i < BLOCKS; i++) pp_cnt_q[i] <= '0;
    end else begin
      state_q <= state_d; op_q <= op_d; tmr_q <= tmr_d; ph_q <= ph_d; idx_q <= idx_d;
      cnt_q <= cnt_d; col_q <= col_d; row_q <= row_d;
      cle_pin_q <= cle_q; ale_pin_q <= ale_q; oe_pin_q <= oe_pin_d; io_pin_q <= io_q;
      cle_q <= cle_d; ale_q <= ale_d; ce_n_q <= ce_n_d; we_n_q <= we_n_d; re_n_q <= re_n_d;
      wg_n_q <= wg_n_d; oe_q <= oe_d; io_q <= io_d; rd_q <= rd_d;
      rdv_q <= rdv_d; take_q <= take_d; done_q <= done_d; ref_q <= ref_d; rdy_q <= rdy_d;
      if (pp_we) pp_cnt_q[pp_idx] <= pp_cnt_d;
    end
  end

  assign req_ready       = rdy_q;
  assign wr_take         = take_q;
  assign rd_data         = rd_q;
  assign rd_valid        = rdv_q;
  assign done            = done_q;
  assign refused         = ref_q;
  assign cmd_latch       = cle_pin_q;
  assign addr_latch      = ale_pin_q;
  assign chip_sel_n      = ce_n_q;
  assign write_strobe_n  = we_n_q;
  assign output_strobe_n = re_n_q;
  assign write_guard_n   = wg_n_q;
  assign io_out          = io_pin_q;
  assign io_oe           = oe_pin_q;

endmodule

// File: nand_card_host_chk.sv
// Pin and request checks for nand_card_host, bound to every instance.
// Sees only the host's ports; one clock, async high reset.
`timescale 1ns/1ps
module nand_card_host_chk
  import nand_host_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       req_ready,
  input wire logic       done,
  input wire logic       refused,
  input wire logic       rd_valid,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic       chip_sel_n,
  input wire logic       write_strobe_n,
  input wire logic       output_strobe_n,
  input wire logic       write_guard_n,
  input wire logic [7:0] io_out,
  input wire logic       io_oe,
  input wire logic       ready_busy_in
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_latch_excl; !(cmd_latch && addr_latch); endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_we_width; $fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width");
  property p_we_drive; !write_strobe_n |-> io_oe && !chip_sel_n; endproperty
  a_we_drive: assert property (p_we_drive) else $error("port not driven");
  property p_re_pins;
    !output_strobe_n |-> !io_oe && !cmd_latch && !addr_latch && !chip_sel_n && write_strobe_n;
  endproperty
  a_re_pins: assert property (p_re_pins) else $error("bad pins on read");
  property p_guard;
    $rose(write_strobe_n) && $past(cmd_latch) && ($past(io_out) == CMD_PROGRAM
      || $past(io_out) == CMD_ERASE_GO) |-> write_guard_n;
  endproperty
  a_guard: assert property (p_guard) else $error("guard low on confirm");
  property p_busy_hold; !ready_busy_in |-> write_strobe_n && output_strobe_n && !chip_sel_n; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("strobe while busy");
  property p_rd_valid; $rose(output_strobe_n) |-> ##[0:2] rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("no byte after strobe");
  property p_idle; req_ready |-> chip_sel_n && !io_oe && !write_guard_n; endproperty
  a_idle: assert property (p_idle) else $error("idle pins wrong");
  property p_done; done |-> chip_sel_n && $past(chip_sel_n, 4); endproperty
  a_done: assert property (p_done) else $error("done before deselect");
  property p_refuse; refused |-> chip_sel_n && $past(req_ready, 2); endproperty
  a_refuse: assert property (p_refuse) else $error("late refusal");
endmodule
bind nand_card_host nand_card_host_chk chk_u (.*);

// File: nand_card_model.sv
// Behavioural flash card: latches, page read, status, busy line.
// Driven by nand_card_host pins; models the ready/busy pull-up.
`timescale 1ns/1ps
module nand_card_model
  import nand_host_pkg::*;
#(
  parameter int         BUSY_NS   = 400,
  parameter logic [7:0] STATUS_OK = 8'hC0
)(
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       chip_sel_n,
  input  wire logic       write_strobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       write_guard_n,
  input  wire logic [7:0] io_out,
  output logic      [7:0] io_in,
  output logic            ready_busy_in
);
  logic [7:0] cmd_q = 8'h00;
  logic [7:0] col_q = 8'h00;
  logic       half_q = 1'b0;
  logic       busy_q = 1'b0;
  int         addr_n = 0;
  int         data_n = 0;
  int         writes_n = 0;
  initial io_in = 8'h00;
  assign ready_busy_in = busy_q ? 1'b0 : 1'b1;
  task automatic go_busy();
    busy_q = 1'b1;
    busy_q <= #(BUSY_NS) 1'b0;
  endtask
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n) begin
      if (cmd_latch) begin
        cmd_q = io_out;
        addr_n = 0;
        if (io_out == CMD_DATA_IN) data_n = 0;
        if (io_out == CMD_READ_LO || io_out == CMD_READ_HI) half_q = io_out[0];
        if ((io_out == CMD_PROGRAM || io_out == CMD_ERASE_GO) && write_guard_n) begin
          writes_n++;
          go_busy();
        end
      end else if (addr_latch) begin
        if (addr_n == 0) col_q = io_out;
        addr_n++;
        if (addr_n == 3 && cmd_q != CMD_DATA_IN) go_busy();
      end else data_n++;
    end
  end
  // Read byte on strobe fall; column advances
  always @(negedge output_strobe_n) begin
    if (!chip_sel_n && !cmd_latch && !addr_latch && write_strobe_n) begin
      io_in = (cmd_q == CMD_STATUS) ? STATUS_OK : col_q ^ {half_q, 7'h00};
      col_q++;
    end
  end
  always @(posedge output_strobe_n) io_in <= #15 ~io_in;
  always @(posedge chip_sel_n) begin
    io_in = ~io_in;
    if (!busy_q) half_q = 1'b0;
  end
endmodule

// File: nand_card_host_test.sv
// Self-checking bench for nand_card_host against nand_card_model.
// Assumes the model and bound checker are compiled first.
`timescale 1ns/1ps
module nand_card_host_test;
  import nand_host_pkg::*;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic             req_valid = 1'b0;
  op_type           req_op = OP_READ;
  logic             req_half = 1'b0;
  logic [7:0]       req_col = 8'h00;
  logic [ROW_W-1:0] req_row = '0;
  logic [LEN_W-1:0] req_len = '0;
  logic             req_bad_block = 1'b0;
  logic [7:0]       wr_data = 8'h00;
  logic             req_ready, wr_take, rd_valid, done, refused, io_oe, ready_busy_in;
  logic             cmd_latch, addr_latch, chip_sel_n, write_strobe_n, output_strobe_n, write_guard_n;
  logic [7:0]       rd_data, io_out, io_in;
  logic [7:0]       got_q[$];
  logic             done_seen, ref_seen;
  int               bad_count = 0;
  int               check_count = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
  nand_card_host  dut_u (.*);
  nand_card_model card_u (.*);
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_seq(input logic [7:0] base, input logic [7:0] flip, input int cnt);
    check_byte(8'(got_q.size()), 8'(cnt));
    foreach (got_q[i]) check_byte(got_q[i], (base + 8'(i)) ^ flip);
  endtask
  task automatic run(input op_type op, input logic half, input logic [7:0] col,
                     input logic [ROW_W-1:0] row, input int len, input logic bad);
    int n;
    n = 0;
    got_q = {};
    done_seen = 1'b0;
    ref_seen = 1'b0;
    do begin @(posedge mclk); n++; end while (req_ready !== 1'b1 && n < 500);
    req_op <= op;
    req_half <= half;
    req_col <= col;
    req_row <= row;
    req_len <= LEN_W'(len);
    req_bad_block <= bad;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    n = 0;
    while (!done_seen && !ref_seen && n < 2000) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
      done_seen = (done === 1'b1);
      ref_seen = (refused === 1'b1);
      n++;
    end
    if (!done_seen && !ref_seen) begin
      bad_count++;
      $display("Error %0t: request not answered", $time);
    end
  endtask
  task automatic t_read();
    run(OP_READ, 1'b0, 8'hFE, 14'h0010, 3, 1'b0);
    check_byte(8'(done_seen), 8'h01);
    check_seq(8'hFE, 8'h00, 3);
    run(OP_READ, 1'b1, 8'h10, 14'h0011, 2, 1'b0);
    check_seq(8'h10, 8'h80, 2);
    run(OP_READ, 1'b0, 8'h10, 14'h0011, 1, 1'b0);
    check_seq(8'h10, 8'h00, 1);
  endtask
  task automatic t_program();
    run(OP_PROGRAM, 1'b0, 8'h00, 14'h0050, 2, 1'b1);
    check_byte(8'(ref_seen), 8'h01);
    run(OP_ERASE, 1'b0, 8'h00, 14'h0050, 0, 1'b1);
    check_byte(8'(ref_seen), 8'h01);
    run(OP_PROGRAM, 1'b0, 8'h04, 14'h0040, 2, 1'b0);
    check_byte(8'(done_seen), 8'h01);
    check_byte(8'(card_u.data_n), 8'h02);
    check_byte(8'(card_u.writes_n), 8'h01);
  endtask
  task automatic t_limit();
    run(OP_ERASE, 1'b0, 8'h00, 14'h0030, 0, 1'b0);
    check_byte(8'(done_seen), 8'h01);
    for (int i = 0; i < 10; i++) begin
      run(OP_PROGRAM, 1'b0, 8'(i), 14'h0030, 1, 1'b0);
      check_byte(8'(done_seen), 8'h01);
    end
    run(OP_PROGRAM, 1'b0, 8'h20, 14'h0031, 1, 1'b0);
    check_byte(8'(ref_seen), 8'h01);
    run(OP_ERASE, 1'b0, 8'h00, 14'h0030, 0, 1'b0);
    check_byte(8'(done_seen), 8'h01);
    run(OP_PROGRAM, 1'b0, 8'h20, 14'h0031, 1, 1'b0);
    check_byte(8'(done_seen), 8'h01);
  endtask
  task automatic t_misc();
    run(OP_STATUS, 1'b0, 8'h00, '0, 1, 1'b0);
    check_seq(8'hC0, 8'h00, 1);
    run(OP_ID, 1'b0, 8'h00, '0, 2, 1'b0);
    check_seq(8'h00, 8'h00, 2);
    run(OP_RESET, 1'b0, 8'h00, '0, 0, 1'b0);
    check_byte(8'(done_seen), 8'h01);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_read();
    t_program();
    t_limit();
    t_misc();
    finish_test();
  end
  initial begin
    #200000;
    bad_count++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
